// File: bench/fifo_host_ctrl_bench.sv
// Self-checking bench for the APB strobe FIFO host
`timescale 1ns/1ps
`include "fifo_host_consts.svh"
module fifo_host_ctrl_bench;
    localparam int DEPTH = 8;
    logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] w, fifo_q;
    logic [8:0] words [$];
    fifo_host_pkg::fifo_pins_out_t pins;
    fifo_host_pkg::fifo_flags_t flags;
    int n_errors, checks_done, wr_falls, rd_falls;
    fifo_host_ctrl u_dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pins, .flags_raw(flags), .read_data_raw(fifo_q));
    strobe_fifo_model #(.DEPTH(DEPTH)) u_fifo (.write_strobe_n(pins.write_strobe_n),
        .read_strobe_n(pins.read_strobe_n), .replay_n(pins.replay_n), .master_clear_n(pins.master_clear_n),
        .wdata(pins.wdata), .flags, .rdata(fifo_q));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(negedge pins.write_strobe_n) wr_falls++;
    always @(negedge pins.read_strobe_n) rd_falls++;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // This wait ends when pready is seen high at a clock edge
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, `FH_OFF_STATUS, 32'h0);
            n++;
        end while (rd[`FH_ST_BUSY_BIT] !== 1'b0 && n < 20);
        // A poll limit that runs out counts as a mismatch
        if (rd[`FH_ST_BUSY_BIT] !== 1'b0) n_errors++;
    endtask
    function automatic logic [31:0] exp_st(input int cnt, input logic refused);
        exp_st = 32'h40;
        exp_st[`FH_ST_EMPTY_BIT] = cnt != 0;
        exp_st[`FH_ST_FULL_BIT] = cnt != DEPTH;
        exp_st[`FH_ST_HALF_BIT] = cnt <= DEPTH / 2;
        exp_st[`FH_ST_REFUSED_BIT] = refused;
    endfunction
    task automatic status(input int cnt, input logic refused);
        apb(1'b0, `FH_OFF_STATUS, 32'h0);
        chk("status", exp_st(cnt, refused), rd & 32'h5F);
        apb(1'b1, `FH_OFF_STATUS, 32'h10);
    endtask
    task automatic rd_word(input logic [8:0] exp);
        apb(1'b1, `FH_OFF_CTRL, 32'h4);
        idle();
        apb(1'b0, `FH_OFF_RDATA, 32'h0);
        chk("rdata", {22'h0, 1'b1, exp}, rd);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        void'($urandom(32'hE6AE));
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        apb(1'b1, `FH_OFF_WDATA, 32'h55);
        idle();
        chk("early writes", 32'h0, 32'(wr_falls));
        chk("early refusal", 32'h1, 32'(rd[`FH_ST_REFUSED_BIT]));
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], err});
        apb(1'b1, `FH_OFF_STATUS, 32'h10);
        apb(1'b1, `FH_OFF_CTRL, 32'h1);
        idle();
        status(0, 1'b0);
        $display("test clear done");
        for (int i = 0; i <= DEPTH; i++) begin
            w = 9'($urandom);
            if (i < DEPTH) words.push_back(w);
            apb(1'b1, `FH_OFF_WDATA, {23'h0, w});
            idle();
            status(i < DEPTH ? i + 1 : DEPTH, i == DEPTH);
        end
        chk("stored writes", DEPTH, 32'(wr_falls));
        $display("test fill done");
        for (int i = 0; i < DEPTH; i++) begin
            rd_word(words[i]);
            status(DEPTH - 1 - i, 1'b0);
        end
        apb(1'b1, `FH_OFF_CTRL, 32'h4);
        idle();
        chk("empty read", {31'(DEPTH), 1'b1}, {rd_falls[30:0], rd[`FH_ST_REFUSED_BIT]});
        $display("test drain done");
        apb(1'b1, `FH_OFF_STATUS, 32'h10);
        apb(1'b1, `FH_OFF_CTRL, 32'h2);
        idle();
        status(DEPTH, 1'b0);
        rd_word(words[0]);
        rd_word(words[1]);
        $display("test replay done");
        apb(1'b1, `FH_OFF_CONFIG, 32'h3);
        chk("depth pins", 32'h0, 32'({pins.first_in_chain_n, pins.cascade_token_in_oe}));
        apb(1'b0, `FH_OFF_CONFIG, 32'h0);
        chk("config", 32'h3, rd);
        apb(1'b1, `FH_OFF_CTRL, 32'h2);
        idle();
        chk("depth replay", 32'h1, 32'(rd[`FH_ST_REFUSED_BIT]));
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        chk("reset pins", 32'h5, 32'({pins.first_in_chain_n, pins.cascade_token_in_n, pins.cascade_token_in_oe}));
        $display("test depth done");
        conclude();
    end
endmodule // fifo_host_ctrl_bench

// File: bench/fifo_host_ctrl_props.sv
// Assertions on the FIFO host's pins
`timescale 1ns/1ps
`include "fifo_host_consts.svh"
module fifo_host_ctrl_props (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire fifo_host_pkg::fifo_pins_out_t pins,
    input wire fifo_host_pkg::fifo_flags_t flags_raw,
    input wire logic [`FH_DATA_W-1:0] read_data_raw
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    wire ws = pins.write_strobe_n;
    wire rs = pins.read_strobe_n;
    wire rt = pins.replay_n;
    wire mc = pins.master_clear_n;
    property p_wr_pulse; $fell(ws) |-> !ws [*3] ##1 ws; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe length wrong");
    property p_rd_pulse; $fell(rs) |-> !rs [*5] ##1 rs; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe length wrong");
    property p_mc_pulse; $fell(mc) |-> !mc [*3] ##1 mc; endproperty
    a_mc_pulse: assert property (p_mc_pulse) else $error("clear pulse length wrong");
    property p_rt_pulse; $fell(rt) |-> !rt [*3] ##1 rt; endproperty
    a_rt_pulse: assert property (p_rt_pulse) else $error("replay pulse length wrong");
    property p_wdata_hold; !ws && !$past(ws) |-> $stable(pins.wdata); endproperty
    a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved under strobe");
    property p_one_op; $onehot0({!ws, !rs, !rt, !mc}); endproperty
    a_one_op: assert property (p_one_op) else $error("two strobes low together");
    property p_mc_rise; $rose(mc) |-> ws && rs && $past(ws) && $past(rs) ##1 ws && rs; endproperty
    a_mc_rise: assert property (p_mc_rise) else $error("strobe low around clear rise");
    property p_depth_replay; !pins.cascade_token_in_oe |-> rt; endproperty
    a_depth_replay: assert property (p_depth_replay) else $error("replay in depth mode");
    c_write: cover property ($fell(ws));
    c_read: cover property ($fell(rs));
    c_replay: cover property ($fell(rt));
    c_clear: cover property ($fell(mc));
endmodule // fifo_host_ctrl_props

bind fifo_host_ctrl fifo_host_ctrl_props u_props (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pins, .flags_raw, .read_data_raw);

// File: bench/strobe_fifo_model.sv
// Behavioural strobe FIFO on the host's far side
`timescale 1ns/1ps
module strobe_fifo_model #(
    parameter int DEPTH = 8
) (
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic replay_n,
    input wire logic master_clear_n,
    input wire logic [8:0] wdata,
    output fifo_host_pkg::fifo_flags_t flags,
    output logic [8:0] rdata
);
    logic [8:0] mem [DEPTH];
    logic [8:0] q = 9'h000;
    int wp = 0;
    int rp = 0;
    int count = 0;
    logic accept = 1'b0;
    logic driving = 1'b0;
    assign flags = {count != 0, count != DEPTH, count <= DEPTH / 2};
    // Floating outputs show the inverse of the last word
    assign rdata = driving ? q : ~q;
    always @(negedge master_clear_n) begin
        wp = 0;
        rp = 0;
        count = 0;
    end
    always @(negedge write_strobe_n) accept = count < DEPTH;
    always @(posedge write_strobe_n) if (accept) begin
        mem[wp % DEPTH] = wdata;
        wp++;
        count++;
    end
    always @(negedge read_strobe_n) if (count > 0) begin
        q = mem[rp % DEPTH];
        rp++;
        count--;
        driving = 1'b1;
    end
    always @(posedge read_strobe_n) driving = 1'b0;
    always @(negedge replay_n) begin
        rp = 0;
        count = wp;
    end
endmodule // strobe_fifo_model

// File: hdl/fifo_host_consts.svh
// Offsets, field positions, reset values and timing counts of the strobe FIFO host
`ifndef FIFO_HOST_CONSTS_SVH
`define FIFO_HOST_CONSTS_SVH

// ==========================================
// Word and clock
`define FH_DATA_W 9
`define FH_CLK_NS 10
`define FH_NS2CYC(ns) (((ns) + `FH_CLK_NS - 1) / `FH_CLK_NS)

// ==========================================
// Pin timing, slowest speed grade
`define FH_STROBE_PULSE_NS 25
`define FH_STROBE_RECOVERY_NS 10
`define FH_ACCESS_NS 25
`define FH_FLAG_DELAY_NS 35
`define FH_MCLR_PULSE_NS 25
`define FH_MCLR_RECOVERY_NS 10
`define FH_REPLAY_PULSE_NS 25
`define FH_REPLAY_RECOVERY_NS 10
`define FH_SYNC_STAGES 2

`define FH_WR_LOW_CYC `FH_NS2CYC(`FH_STROBE_PULSE_NS)
`define FH_RD_LOW_CYC (`FH_NS2CYC(`FH_ACCESS_NS) + `FH_SYNC_STAGES)
`define FH_MC_LOW_CYC `FH_NS2CYC(`FH_MCLR_PULSE_NS)
`define FH_RT_LOW_CYC `FH_NS2CYC(`FH_REPLAY_PULSE_NS)
`define FH_SETTLE_CYC (`FH_NS2CYC(`FH_FLAG_DELAY_NS) + `FH_SYNC_STAGES)

// ==========================================
// Register offsets
`define FH_OFF_CTRL 8'h00
`define FH_OFF_CONFIG 8'h04
`define FH_OFF_WDATA 8'h08
`define FH_OFF_RDATA 8'h0C
`define FH_OFF_STATUS 8'h10

// ==========================================
// Fields
`define FH_CTRL_MCLR_BIT 0
`define FH_CTRL_REPLAY_BIT 1
`define FH_CTRL_READ_BIT 2
`define FH_CFG_DEPTH_BIT 0
`define FH_CFG_FIRST_BIT 1
`define FH_ST_EMPTY_BIT 0
`define FH_ST_FULL_BIT 1
`define FH_ST_HALF_BIT 2
`define FH_ST_BUSY_BIT 3
`define FH_ST_REFUSED_BIT 4
`define FH_ST_RVALID_BIT 5
`define FH_ST_READY_BIT 6
`define FH_RDATA_VALID_BIT 9

// ==========================================
// Reset values
`define FH_CONFIG_RESET 2'h0

`endif

// File: hdl/fifo_host_ctrl.sv
// APB-driven controller that operates a strobe FIFO through its pins
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "fifo_host_consts.svh"

// Functional notes
// - Write strobe held low stores a word
// - Read strobe falling edge fetches next word
// - Both strobes high throughout a replay
// - Master clear pulse before first use
// - Strobes high around master clear rise
module fifo_host_ctrl (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output fifo_host_pkg::fifo_pins_out_t pins,
    input wire fifo_host_pkg::fifo_flags_t flags_raw,
    input wire logic [`FH_DATA_W-1:0] read_data_raw
);

    // ==========================================
    // Pin synchronisers
    fifo_host_pkg::fifo_flags_t flags;
    logic [`FH_DATA_W-1:0] read_data;

    pin_sync #(.WIDTH(3 + `FH_DATA_W), .INIT({3'h7, 9'h000})) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({flags_raw, read_data_raw}),
        .sync_out({flags, read_data})
    );

    // ==========================================
    // State
    fifo_host_pkg::host_state_t state;
    fifo_host_pkg::host_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [1:0] config_reg;
    logic refused;
    logic read_valid;
    logic initialized;
    logic [`FH_DATA_W-1:0] rdata;

    // ==========================================
    // APB decode
    wire apb_access = psel & penable & ~pready;
    wire wr_hit = apb_access & pwrite;
    wire rd_hit = apb_access & ~pwrite;
    wire sel_ctrl = paddr == `FH_OFF_CTRL;
    wire sel_config = paddr == `FH_OFF_CONFIG;
    wire sel_wdata = paddr == `FH_OFF_WDATA;
    wire sel_rdata = paddr == `FH_OFF_RDATA;
    wire sel_status = paddr == `FH_OFF_STATUS;
    wire mapped = sel_ctrl | sel_config | sel_wdata | sel_rdata | sel_status;

    wire depth_mode = config_reg[`FH_CFG_DEPTH_BIT];
    wire idle = state == fifo_host_pkg::ST_IDLE;

    wire req_mclr = wr_hit & sel_ctrl & pwdata[`FH_CTRL_MCLR_BIT];
    wire req_replay = wr_hit & sel_ctrl & pwdata[`FH_CTRL_REPLAY_BIT] & ~req_mclr;
    wire req_read = wr_hit & sel_ctrl & pwdata[`FH_CTRL_READ_BIT] & ~req_mclr & ~pwdata[`FH_CTRL_REPLAY_BIT];
    wire req_write = wr_hit & sel_wdata;

    // Commands only start from idle, and only when the FIFO can take them
    wire go_mclr = req_mclr & idle;
    wire go_replay = req_replay & idle & initialized & ~depth_mode;
    wire go_read = req_read & idle & initialized & flags.empty_flag_n;
    wire go_write = req_write & idle & initialized & flags.full_flag_n;
    wire any_req = req_mclr | req_replay | req_read | req_write;
    wire refuse = any_req & ~(go_mclr | go_replay | go_read | go_write);
    wire clr_refused = wr_hit & sel_status & pwdata[`FH_ST_REFUSED_BIT];
    wire rd_done = (state == fifo_host_pkg::ST_RD_LOW) && (cnt == 4'h0);
    wire mc_done = (state == fifo_host_pkg::ST_MC_LOW) && (cnt == 4'h0);

    // ==========================================
    // Sequencer
    always_comb begin
        next_state = state;
        next_cnt = (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
        unique case (state)
            fifo_host_pkg::ST_IDLE: begin
                if (go_mclr) begin
                    next_state = fifo_host_pkg::ST_MC_LOW;
                    next_cnt = 4'(`FH_MC_LOW_CYC - 1);
                end else if (go_replay) begin
                    next_state = fifo_host_pkg::ST_RT_LOW;
                    next_cnt = 4'(`FH_RT_LOW_CYC - 1);
                end else if (go_read) begin
                    next_state = fifo_host_pkg::ST_RD_LOW;
                    next_cnt = 4'(`FH_RD_LOW_CYC - 1);
                end else if (go_write) begin
                    next_state = fifo_host_pkg::ST_WR_LOW;
                    next_cnt = 4'(`FH_WR_LOW_CYC - 1);
                end
            end
            fifo_host_pkg::ST_WR_LOW,
            fifo_host_pkg::ST_RD_LOW,
            fifo_host_pkg::ST_MC_LOW,
            fifo_host_pkg::ST_RT_LOW: begin
                if (cnt == 4'h0) begin
                    // Recovery also covers flag delay plus synchroniser
                    next_state = fifo_host_pkg::ST_SETTLE;
                    next_cnt = 4'(`FH_SETTLE_CYC - 1);
                end
            end
            fifo_host_pkg::ST_SETTLE: begin
                if (cnt == 4'h0) begin
                    next_state = fifo_host_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // ==========================================
    // Pin drive
    fifo_host_pkg::fifo_pins_out_t next_pins;
    always_comb begin
        next_pins = pins;
        // Strobes stay high through clear and replay
        next_pins.write_strobe_n = next_state != fifo_host_pkg::ST_WR_LOW;
        next_pins.read_strobe_n = next_state != fifo_host_pkg::ST_RD_LOW;
        next_pins.master_clear_n = next_state != fifo_host_pkg::ST_MC_LOW;
        next_pins.replay_n = next_state != fifo_host_pkg::ST_RT_LOW;
        // Standalone straps: token in grounded, first-load high
        next_pins.first_in_chain_n = ~(depth_mode & config_reg[`FH_CFG_FIRST_BIT]);
        next_pins.cascade_token_in_n = 1'b0;
        next_pins.cascade_token_in_oe = ~depth_mode;
        if (go_write) begin
            next_pins.wdata = pwdata[`FH_DATA_W-1:0];
        end
    end

    // ==========================================
    // APB read mux
    logic [31:0] next_prdata;
    wire [31:0] status_word = {25'h0, initialized, read_valid, refused, ~idle,
        flags.half_full_flag_n, flags.full_flag_n, flags.empty_flag_n};
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (rd_hit && sel_config) begin
            next_prdata = {30'h0, config_reg};
        end else if (rd_hit && sel_rdata) begin
            next_prdata = {22'h0, read_valid, rdata};
        end else if (rd_hit && sel_status) begin
            next_prdata = status_word;
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= fifo_host_pkg::ST_IDLE;
            cnt <= 4'h0;
            pins <= '{write_strobe_n: 1'b1, read_strobe_n: 1'b1, replay_n: 1'b1, master_clear_n: 1'b1,
                first_in_chain_n: 1'b1, cascade_token_in_n: 1'b0, cascade_token_in_oe: 1'b1, wdata: 9'h000};
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            pins <= next_pins;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            config_reg <= `FH_CONFIG_RESET;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= apb_access & ~mapped;
            prdata <= next_prdata;
            if (wr_hit && sel_config) begin
                config_reg <= pwdata[1:0];
            end
        end
    end

    // Sticky bits: the setting event wins over a clear in the same cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            refused <= 1'b0;
            read_valid <= 1'b0;
            initialized <= 1'b0;
            rdata <= 9'h000;
        end else begin
            refused <= refuse | (refused & ~clr_refused);
            read_valid <= rd_done | (read_valid & ~(rd_hit & sel_rdata));
            initialized <= initialized | mc_done;
            if (rd_done) begin
                rdata <= read_data;
            end
        end
    end

endmodule // fifo_host_ctrl

// File: hdl/fifo_host_pkg.sv
// Types of the strobe FIFO host
package fifo_host_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WR_LOW,
        ST_RD_LOW,
        ST_MC_LOW,
        ST_RT_LOW,
        ST_SETTLE
    } host_state_t;

    // Pins driven toward the FIFO
    typedef struct packed {
        logic write_strobe_n;
        logic read_strobe_n;
        logic replay_n;
        logic master_clear_n;
        logic first_in_chain_n;
        logic cascade_token_in_n;
        logic cascade_token_in_oe;
        logic [8:0] wdata;
    } fifo_pins_out_t;

    // Flags coming back from the FIFO
    typedef struct packed {
        logic empty_flag_n;
        logic full_flag_n;
        logic half_full_flag_n;
    } fifo_flags_t;

endpackage

// File: hdl/pin_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stage1 <= INIT;
            sync_out <= INIT;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // pin_sync
